// File: hw/c8b_codec.sv
// 8b/10b character codec: host byte port to a serial bit stream and back
// assumes host and serial inputs are synchronous to mclk; receive alignment comes from serInFirst
//
// Contract
// - each host byte with its flag becomes one ten-bit character that is shifted out one bit per clock.
// - received bits are gathered ten at a time and each data character is turned back into its byte.
// - every byte value has an encoding and spare patterns carry the special characters.
// - host data bit 0 is code letter A and bit 7 is letter H.
// - encoded bits a..h follow A..H while i comes from A..E and j from F..H.
// - a character splits into abcdei coding EDCBA and fghj coding HGF.
// - a flag beside each character is low for data and high for a special character.
// - a data character is named by EDCBA as xx and HGF as y.
// - bits go out in the order a, b, c, d, e, i, f, g, h, j.
// - disparity moves after each sub-block by its weight or its tie pattern, else it holds.
// - a character missing from the column of the current disparity is a violation yet still moves disparity.
`timescale 1ns/1ps

`include "c8b_codec_regs.svh"

module c8b_codec (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // host transmit side
  input  wire c8b_pkg::c8b_char_t   txChar,
  input  wire logic                 txValid,
  output logic                      txReady,
  // serial stream out
  output logic                      serOut,
  output logic                      serFirst,
  // serial stream in
  input  wire logic                 serIn,
  input  wire logic                 serInFirst,
  // host receive side
  output c8b_pkg::c8b_char_t        rxChar,
  output logic                      rxValid,
  output logic                      rxViolation,
  // disparity status
  output logic                      txDisparity,
  output logic                      rxDisparity
);

  // ==================================================
  // receive decode helpers

  // abcdei to {special K28 block, EDCBA}; unknown blocks give zero and fail the check
  function automatic logic [5:0] dec6(input logic [5:0] s);
    logic [5:0] r;
    logic [5:0] n;
    r = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = c8b_pkg::c8b_tbl6(5'(i));
      if (s == n || s == c8b_pkg::c8b_pos6(n)) r = {1'h0, 5'(i)};
    end
    if (s == `C8B_K28_6B || s == ~`C8B_K28_6B) r = {1'h1, `C8B_K28_X};
    return r;
  endfunction : dec6

  // fghj to HGF, alternate .7 forms included; behind the inverted K28 block the balanced
  // forms arrive complemented, so they are folded back first, else .1/.6 and .2/.5 alias
  function automatic logic [2:0] dec4(input logic [3:0] s, input logic k28Flip);
    logic [2:0] r;
    logic [3:0] n;
    logic [3:0] t;
    logic       bal;
    bal = c8b_pkg::c8b_ones({2'h0, s}) == `C8B_BAL4 && s != `C8B_PLUS4 && s != `C8B_MINUS4;
    t   = (k28Flip && bal) ? ~s : s;
    r   = 3'h0;
    for (int i = 0; i < 8; i++) begin
      n = c8b_pkg::c8b_tbl4(3'(i));
      if (t == n || t == c8b_pkg::c8b_pos4(n)) r = 3'(i);
    end
    if (t == `C8B_ALT7 || t == ~`C8B_ALT7) r = `C8B_Y7;
    return r;
  endfunction : dec4

  // ==================================================
  // transmit registers
  logic [3:0] txCnt_r;
  logic [3:0] txCnt_nxt;
  logic [9:0] txShift_r;
  logic [9:0] txShift_nxt;
  logic       txRd_r;
  logic       txRd_nxt;
  logic       txReady_r;
  logic       serFirst_r;

  // ==================================================
  // transmit slot selection
  // a new character enters only on the last bit slot, so the link never stalls mid character
  wire logic txLoad = txCnt_r == `C8B_LAST_BIT;
  wire logic txTake = txLoad && txValid && txReady_r;

  // an empty slot is filled with the comma special so the line keeps transitions and balance
  wire logic       encFlag = txTake ? txChar.specialFlag : `C8B_IDLE_FLAG;
  wire logic [7:0] encByte = txTake ? txChar.data : `C8B_IDLE_BYTE;
  wire logic [9:0] encCode;
  wire logic       encRd;

  // transmit encoder, same core as the receive check so both agree on every pattern
  c8b_enc_core txEnc (
    .specialFlag (encFlag),
    .dataByte    (encByte),
    .rdIn        (txRd_r),
    .code        (encCode),
    .rdOut       (encRd)
  );

  // next-state terms of the serializer
  assign txCnt_nxt   = txLoad ? `C8B_FIRST_BIT : txCnt_r + 4'h1;
  assign txShift_nxt = txLoad ? encCode : {txShift_r[8:0], 1'h0};
  assign txRd_nxt    = txLoad ? encRd : txRd_r;

  // serializer state, one bit per clock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txCnt_r    <= `C8B_LAST_BIT;
      txShift_r  <= 10'h000;
      txRd_r     <= `C8B_RD_NEG;
      txReady_r  <= 1'h1;
      serFirst_r <= 1'h0;
    end else begin
      txCnt_r    <= txCnt_nxt;
      txShift_r  <= txShift_nxt;
      txRd_r     <= txRd_nxt;
      txReady_r  <= txCnt_nxt == `C8B_LAST_BIT;
      serFirst_r <= txLoad;
    end
  end

  assign txReady     = txReady_r;
  assign serOut      = txShift_r[9];
  assign serFirst    = serFirst_r;
  assign txDisparity = txRd_r;

  // ==================================================
  // receive registers
  logic [3:0]         rxCnt_r;
  logic [3:0]         rxCnt_nxt;
  logic [8:0]         rxShift_r;
  logic               rxRd_r;
  logic               rxRd_nxt;
  c8b_pkg::c8b_char_t rxChar_r;
  logic               rxValid_r;
  logic               rxViol_r;

  // ==================================================
  // deserializer framing
  // serInFirst restarts the count on bit a; without it the count free runs from reset
  wire logic [3:0] rxCntEff = serInFirst ? `C8B_FIRST_BIT : rxCnt_r;
  wire logic       rxDone   = rxCntEff == `C8B_LAST_BIT;
  wire logic [9:0] rxWord   = {rxShift_r[8:0], serIn};
  assign rxCnt_nxt = rxDone ? `C8B_FIRST_BIT : rxCntEff + 4'h1;

  // ==================================================
  // character decode
  wire logic [5:0] dec6Res = dec6(rxWord[9:4]);
  wire logic [2:0] rxHigh  = dec4(rxWord[3:0], rxWord[9:4] == ~`C8B_K28_6B);
  wire logic [4:0] rxLow   = dec6Res[4:0];
  // alternate .7 with these low blocks only exists as a special
  wire logic rxAlt = rxWord[3:0] == `C8B_ALT7 || rxWord[3:0] == ~`C8B_ALT7;
  wire logic rxKAltX = rxLow == `C8B_KALT_X0 || rxLow == `C8B_KALT_X1 ||
                       rxLow == `C8B_KALT_X2 || rxLow == `C8B_KALT_X3;
  wire logic       rxSpecial = dec6Res[5] || (rxAlt && rxKAltX);
  wire logic [7:0] rxByte    = {rxHigh, rxLow};
  wire logic [9:0] chkCode;

  // re-encode with the receiver disparity: any difference means the character is not in that column
  c8b_enc_core rxChk (
    .specialFlag (rxSpecial),
    .dataByte    (rxByte),
    .rdIn        (rxRd_r),
    .code        (chkCode),
    .rdOut       ()
  );

  wire logic rxBad = chkCode != rxWord;
  // disparity follows the received bits whatever their validity
  assign rxRd_nxt = rxDone ? c8b_pkg::c8b_rd4(rxWord[3:0], c8b_pkg::c8b_rd6(rxWord[9:4], rxRd_r)) : rxRd_r;

  // deserializer and registered decode results
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxCnt_r   <= `C8B_FIRST_BIT;
      rxShift_r <= 9'h000;
      rxRd_r    <= `C8B_RD_NEG;
      rxChar_r  <= '0;
      rxValid_r <= 1'h0;
      rxViol_r  <= 1'h0;
    end else begin
      rxCnt_r   <= rxCnt_nxt;
      rxShift_r <= rxWord[8:0];
      rxRd_r    <= rxRd_nxt;
      rxValid_r <= rxDone;
      rxViol_r  <= rxDone && rxBad;
      if (rxDone) begin
        rxChar_r <= '{specialFlag: rxSpecial, data: rxByte};
      end
    end
  end

  assign rxChar      = rxChar_r;
  assign rxValid     = rxValid_r;
  assign rxViolation = rxViol_r;
  assign rxDisparity = rxRd_r;

endmodule : c8b_codec

// File: hw/c8b_codec_regs.svh
// named constants of the 8b/10b character codec: code patterns, counts, reset values
// assumes it is included by bare name from the package and the codec modules
`ifndef C8B_CODEC_REGS_SVH
`define C8B_CODEC_REGS_SVH

// ==================================================
// running disparity
`define C8B_RD_NEG     1'h0
`define C8B_BAL6       3'h3
`define C8B_BAL4       3'h2
`define C8B_PLUS6      6'h07
`define C8B_MINUS6     6'h38
`define C8B_PLUS4      4'h3
`define C8B_MINUS4     4'hC

// ==================================================
// special patterns
`define C8B_K28_6B     6'h0F
`define C8B_K28_X      5'h1C
`define C8B_ALT7       4'h7
`define C8B_Y7         3'h7
`define C8B_ALTN_X0    5'h11
`define C8B_ALTN_X1    5'h12
`define C8B_ALTN_X2    5'h14
`define C8B_ALTP_X0    5'h0B
`define C8B_ALTP_X1    5'h0D
`define C8B_ALTP_X2    5'h0E
`define C8B_KALT_X0    5'h17
`define C8B_KALT_X1    5'h1B
`define C8B_KALT_X2    5'h1D
`define C8B_KALT_X3    5'h1E

// ==================================================
// serial framing
`define C8B_FIRST_BIT  4'h0
`define C8B_LAST_BIT   4'h9
`define C8B_IDLE_BYTE  8'hBC
`define C8B_IDLE_FLAG  1'h1

`endif

// File: hw/c8b_enc_core.sv
// combinational 8b/10b encoder: one byte plus flag and entry disparity to one character
// assumes the caller registers code and exit disparity; code[9] is bit a, code[0] is bit j
`timescale 1ns/1ps

`include "c8b_codec_regs.svh"

module c8b_enc_core (
  // character in
  input  wire logic       specialFlag,
  input  wire logic [7:0] dataByte,
  input  wire logic       rdIn,
  // character out
  output logic [9:0]      code,
  output logic            rdOut
);

  // ==================================================
  // sub-block split
  wire logic [4:0] lowBits  = dataByte[4:0];          // EDCBA, bit 0 is A
  wire logic [2:0] highBits = dataByte[7:5];          // HGF
  wire logic       isK28    = specialFlag && lowBits == `C8B_K28_X;

  // six-bit block from EDCBA, bit i comes from A..E
  wire logic [5:0] neg6  = isK28 ? `C8B_K28_6B : c8b_pkg::c8b_tbl6(lowBits);
  wire logic [5:0] sub6  = rdIn ? c8b_pkg::c8b_pos6(neg6) : neg6;
  wire logic       rdMid = c8b_pkg::c8b_rd6(sub6, rdIn);

  // alternate .7 avoids a run of five; specials always use it
  wire logic altNeg = !rdMid && (lowBits == `C8B_ALTN_X0 || lowBits == `C8B_ALTN_X1 || lowBits == `C8B_ALTN_X2);
  wire logic altPos = rdMid && (lowBits == `C8B_ALTP_X0 || lowBits == `C8B_ALTP_X1 || lowBits == `C8B_ALTP_X2);
  wire logic useAlt = highBits == `C8B_Y7 && (specialFlag || altNeg || altPos);

  // four-bit block from HGF, bit j comes from F..H
  wire logic [3:0] neg4   = useAlt ? `C8B_ALT7 : c8b_pkg::c8b_tbl4(highBits);
  wire logic [3:0] pos4   = c8b_pkg::c8b_pos4(neg4);
  // K28 inverts balanced fghj after a negative six-bit block
  wire logic       k28Inv = isK28 && !rdMid && pos4 == neg4 && neg4 != `C8B_MINUS4;
  wire logic [3:0] sub4   = rdMid ? pos4 : (k28Inv ? ~neg4 : neg4);

  // a..e, i, f..h, j in transmit order
  assign code  = {sub6, sub4};
  assign rdOut = c8b_pkg::c8b_rd4(sub4, rdMid);

endmodule : c8b_enc_core

// File: hw/c8b_pkg.sv
// types and sub-block helpers shared by the codec and its encoder core
// assumes the constants header is on the include path
`include "c8b_codec_regs.svh"

package c8b_pkg;

  // ==================================================
  // host character carrier
  typedef struct packed {
    logic       specialFlag;
    logic [7:0] data;
  } c8b_char_t;

  // count of ones in a sub-block, four-bit blocks padded with zeros
  function automatic logic [2:0] c8b_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction : c8b_ones

  // disparity after a six-bit sub-block
  function automatic logic c8b_rd6(input logic [5:0] s, input logic rd);
    logic [2:0] n;
    n = c8b_ones(s);
    if (n > `C8B_BAL6 || s == `C8B_PLUS6) return 1'h1;
    if (n < `C8B_BAL6 || s == `C8B_MINUS6) return 1'h0;
    return rd;
  endfunction : c8b_rd6

  // disparity after a four-bit sub-block
  function automatic logic c8b_rd4(input logic [3:0] s, input logic rd);
    logic [2:0] n;
    n = c8b_ones({2'h0, s});
    if (n > `C8B_BAL4 || s == `C8B_PLUS4) return 1'h1;
    if (n < `C8B_BAL4 || s == `C8B_MINUS4) return 1'h0;
    return rd;
  endfunction : c8b_rd4

  // abcdei for EDCBA, negative column
  function automatic logic [5:0] c8b_tbl6(input logic [4:0] x);
    logic [5:0] t [32];
    t = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
          6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
          6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
          6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    return t[x];
  endfunction : c8b_tbl6

  // fghj for HGF, negative column, primary forms
  function automatic logic [3:0] c8b_tbl4(input logic [2:0] y);
    logic [3:0] t [8];
    t = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    return t[y];
  endfunction : c8b_tbl4

  // positive column: unbalanced blocks and the two tie patterns flip
  function automatic logic [5:0] c8b_pos6(input logic [5:0] n);
    return (c8b_ones(n) != `C8B_BAL6 || n == `C8B_MINUS6) ? ~n : n;
  endfunction : c8b_pos6

  function automatic logic [3:0] c8b_pos4(input logic [3:0] n);
    return (c8b_ones({2'h0, n}) != `C8B_BAL4 || n == `C8B_MINUS4) ? ~n : n;
  endfunction : c8b_pos4

endpackage : c8b_pkg

// File: testbench/c8b_codec_bench.sv
// self-checking bench of the character codec with its line looped back
// assumes the partner model and the checker are compiled beforehand
`timescale 1ns/1ps

module c8b_codec_bench;
  logic               mclk;
  logic               arst_n;
  logic               txValid;
  logic               corruptReq;
  c8b_pkg::c8b_char_t txChar;
  c8b_pkg::c8b_char_t rxChar;
  logic               txReady, serOut, serFirst, serIn, serInFirst;
  logic               rxValid, rxViolation, txDisparity, rxDisparity;
  logic               lineDone, violOk, violSeen;
  logic [9:0]         lineWord;
  logic [7:0]         sentQ [$];
  int                 mismatches, tests_run, cycles;

  c8b_codec c8b_codec_i (.mclk(mclk), .arst_n(arst_n), .txChar(txChar), .txValid(txValid),
    .txReady(txReady), .serOut(serOut), .serFirst(serFirst), .serIn(serIn), .serInFirst(serInFirst),
    .rxChar(rxChar), .rxValid(rxValid), .rxViolation(rxViolation), .txDisparity(txDisparity),
    .rxDisparity(rxDisparity));
  c8b_link_partner c8b_link_partner_i (.mclk(mclk), .arst_n(arst_n), .serOut(serOut),
    .serFirst(serFirst), .corruptReq(corruptReq), .serIn(serIn), .serInFirst(serInFirst),
    .lineWord(lineWord), .lineDone(lineDone));

  // ==================================================
  // compare and verdict
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // ==================================================
  // scenarios; all driving happens at falling edges
  task automatic do_reset();
    arst_n = 1'b0;
    violOk = 1'b0;
    violSeen = 1'b0;
    sentQ.delete();
    repeat (8) @(negedge mclk);
    check("reset ready", 10'(txReady), 10'h001);
    check("reset disparity", 10'({txDisparity, rxDisparity}), 10'h000);
    check("reset rx valid", 10'(rxValid), 10'h000);
    arst_n = 1'b1;
  endtask : do_reset

  // valid stays up after return so back-to-back slots are used
  task automatic send(input logic flag, input logic [7:0] b);
    txChar = '{flag, b};
    txValid = 1'b1;
    while (txReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    if (!flag) sentQ.push_back(b);
  endtask : send

  task automatic serial_order();
    send(1'b0, 8'h45);
    txValid = 1'b0;
    check("tx disparity", 10'(txDisparity), 10'h000);
    for (int k = 0; k < 30 && lineDone !== 1'b1; k++) @(negedge mclk);
    check("line word", lineWord, 10'h295);
  endtask : serial_order

  task automatic all_bytes();
    send(1'b1, 8'hBC);
    for (int v = 0; v < 256; v++) send(1'b0, 8'(v));
    txValid = 1'b0;
    repeat (40) @(negedge mclk);
    check("rx queue left", 10'(sentQ.size()), 10'h000);
    check("idle char", 10'(rxChar), 10'h1BC);
  endtask : all_bytes

  task automatic line_violation();
    violOk = 1'b1;
    corruptReq = 1'b1;
    for (int k = 0; k < 60 && !violSeen; k++) @(negedge mclk);
    corruptReq = 1'b0;
    check("violation seen", 10'(violSeen), 10'h001);
  endtask : line_violation

  // ==================================================
  // receive monitor: data against the queue, idles skipped
  always @(negedge mclk) begin
    if (arst_n && rxValid === 1'b1) begin
      if (violOk) begin
        if (rxViolation === 1'b1 && !violSeen) check("rx disparity", 10'(rxDisparity), 10'h001);
        if (rxViolation === 1'b1) violSeen = 1'b1;
      end else begin
        check("rx violation", 10'(rxViolation), 10'h000);
        if (rxChar !== 9'h1BC) check("rx char", 10'(rxChar), {2'h0, sentQ.pop_front()});
      end
    end
  end

  // clock, and a ceiling well above the expected run of some 2700 cycles
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    txValid = 1'b0;
    txChar = '0;
    corruptReq = 1'b0;
    do_reset();
    serial_order();
    all_bytes();
    line_violation();
    do_reset();
    serial_order();
    final_report();
  end
endmodule : c8b_codec_bench

bind c8b_codec c8b_codec_checker c8b_codec_checker_i (.mclk(mclk), .arst_n(arst_n), .txChar(txChar),
  .txValid(txValid), .txReady(txReady), .serOut(serOut), .serFirst(serFirst), .serIn(serIn),
  .serInFirst(serInFirst), .rxChar(rxChar), .rxValid(rxValid), .rxViolation(rxViolation),
  .txDisparity(txDisparity), .rxDisparity(rxDisparity));

// File: testbench/c8b_codec_checker.sv
// concurrent checks on the ports of the character codec
// assumes a bind from the bench top file; one clock, async active-low reset
`timescale 1ns/1ps

module c8b_codec_checker (
  // clock and reset
  input wire logic               mclk,
  input wire logic               arst_n,
  // host transmit side
  input wire c8b_pkg::c8b_char_t txChar,
  input wire logic               txValid,
  input wire logic               txReady,
  // serial line
  input wire logic               serOut,
  input wire logic               serFirst,
  input wire logic               serIn,
  input wire logic               serInFirst,
  // host receive side and status
  input wire c8b_pkg::c8b_char_t rxChar,
  input wire logic               rxValid,
  input wire logic               rxViolation,
  input wire logic               txDisparity,
  input wire logic               rxDisparity
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ==================================================
  // frame sequences
  sequence rxFrame_s;
    serInFirst ##1 (!serInFirst) [*8] ##1 !serInFirst;
  endsequence
  sequence txGap_s;
    (!serFirst) [*8] ##1 !serFirst ##1 serFirst;
  endsequence

  // ==================================================
  // transmit timing
  frame_period_a: assert property (serFirst |=> txGap_s)
    else $error("serial frame not ten bits");
  ready_load_a: assert property (txReady |=> serFirst)
    else $error("slot not followed by bit a");
  ready_slot_a: assert property (serFirst |-> ##9 txReady)
    else $error("ready not at last bit slot");
  tx_disp_move_a: assert property (!$stable(txDisparity) |-> serFirst)
    else $error("tx disparity moved off a load");

  // ==================================================
  // receive timing; disparity only moves with a finished character
  rx_latency_a: assert property (rxFrame_s |=> rxValid)
    else $error("no character after ten bits");
  rx_single_a: assert property (rxValid |=> !rxValid)
    else $error("rx valid longer than one cycle");
  viol_valid_a: assert property (rxViolation |-> rxValid)
    else $error("violation without a character");
  rx_char_hold_a: assert property (!$stable(rxChar) |-> rxValid)
    else $error("rx char changed without valid");
  rx_disp_hold_a: assert property (!$stable(rxDisparity) |-> rxValid)
    else $error("rx disparity changed without valid");
endmodule : c8b_codec_checker

// File: testbench/c8b_link_partner.sv
// remote end of the serial line: gathers each frame and loops the line back
// assumes serFirst marks bit a; corruptReq forces whole frames to all ones
`timescale 1ns/1ps

module c8b_link_partner (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // line from the codec, and the corruption request from the bench
  input  wire logic serOut,
  input  wire logic serFirst,
  input  wire logic corruptReq,
  // line back to the codec
  output logic      serIn,
  output logic      serInFirst,
  // last whole character, bit a on top
  output logic [9:0] lineWord,
  output logic      lineDone
);
  logic [3:0] cnt_r;
  logic       badHold_r;
  logic       bad;

  // forcing starts on a frame mark so a whole character is spoilt, not half
  assign bad        = (serFirst & corruptReq) | (badHold_r & ~serFirst);
  assign serIn      = bad | serOut;
  assign serInFirst = serFirst;

  // ten bits behind each mark, first bit ends up on top
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lineWord  <= 10'h000;
      cnt_r     <= 4'h0;
      badHold_r <= 1'b0;
      lineDone  <= 1'b0;
    end else begin
      badHold_r <= bad;
      lineWord  <= {lineWord[8:0], serOut};
      cnt_r     <= serFirst ? 4'h1 : cnt_r + 4'h1;
      lineDone  <= (cnt_r == 4'h9);
    end
  end
endmodule : c8b_link_partner
